// >>> core/eqc_pkg.sv
// Package: register map, field positions and reset values of the config bank
package eqc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00; // Mode control
  localparam logic [7:0] OFS_THRESHOLD = 8'h01; // input_threshold_shift
  localparam logic [7:0] OFS_EMPHASIS  = 8'h02; // output_emphasis
  localparam logic [7:0] OFS_SWING     = 8'h03; // output_swing
  localparam logic [7:0] OFS_BANDWIDTH = 8'h07; // filter_bandwidth_select
  localparam logic [7:0] OFS_ABSENCE   = 8'h0b; // absence_level_select
  localparam logic [7:0] OFS_EFF_BW    = 8'h0e; // effective_bandwidth (RO)
  localparam logic [7:0] OFS_EFF_LVL   = 8'h0f; // effective_absence_level
  // ==========================================================
  // Field positions
  localparam int BIT_SERIAL_SEL   = 0; // serial_config_select
  localparam int BIT_PIN_OVERRIDE = 7; // absence_level_pin_override
  localparam int BIT_OVR_ENABLE   = 7; // Override enable in regs 7 and 11
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [3:0] RST_EMPHASIS  = 4'h0;
  localparam logic [1:0] RST_SWING     = 2'h1;
  localparam logic [7:0] RST_BANDWIDTH = 8'h00;
  localparam logic [7:0] RST_ABSENCE   = 8'h00;
  // ==========================================================
  // Decode constants
  localparam logic [7:0] THR_MID      = 8'h80; // Second zero-shift code
  localparam logic [1:0] SWING_300    = 2'h0;  // Level index 300 mVp-p
  localparam logic [1:0] SWING_600    = 2'h1;  // Level index 600 mVp-p
  localparam logic [1:0] SWING_900    = 2'h2;  // Level index 900 mVp-p
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// >>> core/eqc_config_regs.sv
// Equalizer configuration register bank with two-wire serial slave
`timescale 1ns/1ps
// What this block does
// - Emphasis code in reg 2, default zero
// - Swing code in reg 3, default 01
// - Reg 7 bit 7 picks code or fixed bandwidth
// - Bandwidth code 0 maximum, 15 minimum
// - Reg 11 bit 7 picks code or fixed level
// - Absence level code 0 minimum, 127 maximum
// - Reg 14 reports effective bandwidth, read only
// - Reg 15 reports effective absence level, read only
// - Reg 1 threshold code applied to input
// - Threshold 0/128 zero, low positive, high negative
// - Reg 0 bit 0 picks registers or pins
// - Reg 0 bit 7 gives level to pin
module eqc_config_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a,     // Arbitrary neutral address
  parameter logic [3:0] BW_FIXED_CODE = 4'h0,   // Code standing for 9.1 GHz
  parameter logic [6:0] LVL_FIXED_CODE = 7'h10  // Code standing for 50 mVp-p
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // Two-wire serial pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n_out,
  // External setting pins
  input  wire logic [3:0]        pin_emphasis_in,
  input  wire logic [1:0]        pin_swing_in,
  input  wire logic [7:0]        pin_threshold_in,
  input  wire logic [6:0]        absence_level_pin_in,
  // Settings in effect for the analog path
  output logic [3:0]             emphasis_code_out,
  output logic [2:0]             emphasis_step_out,
  output logic [1:0]             swing_level_out,
  output logic signed [7:0]      threshold_shift_out,
  output logic [3:0]             bandwidth_code_out,
  output logic [6:0]             absence_level_out
);
  // ==========================================================
  // Functions
  // Emphasis code to step index 0..7; unlisted codes give no emphasis
  function automatic logic [2:0] emph_step(input logic [3:0] c);
    case (c)
      4'h1:    emph_step = 3'h1;
      4'h3:    emph_step = 3'h2;
      4'h4:    emph_step = 3'h3;
      4'h5:    emph_step = 3'h4;
      4'h7:    emph_step = 3'h5;
      4'hc:    emph_step = 3'h6;
      4'hd:    emph_step = 3'h7;
      default: emph_step = 3'h0;
    endcase
  endfunction
  // Swing code to level index; 01 and 10 both give 600 mVp-p
  function automatic logic [1:0] swing_lvl(input logic [1:0] c);
    case (c)
      2'h0:    swing_lvl = eqc_pkg::SWING_300;
      2'h3:    swing_lvl = eqc_pkg::SWING_900;
      default: swing_lvl = eqc_pkg::SWING_600;
    endcase
  endfunction
  // Threshold code to signed shift; magnitude largest at 1 and 255
  function automatic logic signed [7:0] thr_shift(input logic [7:0] c);
    if (c == 8'h00 || c == eqc_pkg::THR_MID)
      thr_shift = 8'sh00;
    else if (c < eqc_pkg::THR_MID)
      thr_shift = $signed(eqc_pkg::THR_MID - c);
    else
      thr_shift = $signed(eqc_pkg::THR_MID - c);
  endfunction

  // ==========================================================
  // Input synchronisers
  localparam int SW = 23;
  logic [SW-1:0] sync1_r;  // First stage, read only by second stage
  logic [SW-1:0] sync2_r;  // Settled copy
  logic          scl_d_r;  // Delayed scl for edge detect
  logic          sda_d_r;  // Delayed sda for start/stop detect
  // Two flops on every pin; the setting pins are quasi-static straps
  always_ff @(posedge sys_clk_in) begin
    sync1_r <= {scl_in, sda_in, pin_emphasis_in, pin_swing_in,
                pin_threshold_in, absence_level_pin_in};
    sync2_r <= sync1_r;
    scl_d_r <= sync2_r[22];
    sda_d_r <= sync2_r[21];
  end
  logic       scl_s;
  logic       sda_s;
  logic [3:0] pin_emph_s;
  logic [1:0] pin_swing_s;
  logic [7:0] pin_thr_s;
  logic [6:0] pin_lvl_s;
  assign {scl_s, sda_s, pin_emph_s, pin_swing_s, pin_thr_s, pin_lvl_s} =
         sync2_r;
  logic scl_rise;   // Data sample point
  logic scl_fall;   // Data change point
  logic start_det;  // Start or repeated start
  logic stop_det;   // Stop
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================
  // Serial slave state machine
  typedef enum logic [2:0] {
    EQC_IDLE, EQC_RX, EQC_ACK, EQC_TX, EQC_RACK
  } eqc_state_t;
  eqc_state_t state_r;
  logic [3:0] bit_cnt_r;   // Bits moved in current byte
  logic [7:0] shift_r;     // Shift register
  logic [1:0] phase_r;     // 0 address, 1 pointer, 2 data
  logic       read_r;      // Read transfer
  logic       nack_r;      // Master declined more data
  logic [7:0] ptr_r;       // Register pointer, auto-increments
  logic       wr_stb;      // Write strobe for one cycle
  logic [7:0] rd_data;     // Read mux result
  logic [7:0] rx_byte;     // Byte just completed
  assign rx_byte = shift_r;
  assign wr_stb  = (state_r == EQC_RX) && scl_fall &&
                   (bit_cnt_r == eqc_pkg::BITS_PER_BYTE) && (phase_r == 2'h2);

  // Protocol sequencing; start and stop win over bit events
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_r      <= EQC_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      phase_r      <= 2'h0;
      read_r       <= 1'b0;
      nack_r       <= 1'b0;
      ptr_r        <= 8'h00;
      sda_oe_n_out <= 1'b1;
    end else if (start_det) begin
      state_r      <= EQC_RX;
      bit_cnt_r    <= 4'h0;
      phase_r      <= 2'h0;
      sda_oe_n_out <= 1'b1;
    end else if (stop_det) begin
      state_r      <= EQC_IDLE;
      sda_oe_n_out <= 1'b1;
    end else begin
      case (state_r)
        EQC_RX: begin
          if (scl_rise && bit_cnt_r != eqc_pkg::BITS_PER_BYTE) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall &&
                       bit_cnt_r == eqc_pkg::BITS_PER_BYTE) begin
            // Whole byte in: acknowledge it unless another slave's
            if (phase_r == 2'h0 && rx_byte[7:1] != SLAVE_ADDR) begin
              state_r <= EQC_IDLE;
            end else begin
              state_r      <= EQC_ACK;
              sda_oe_n_out <= 1'b0;
              if (phase_r == 2'h0)
                read_r <= rx_byte[0];
              if (phase_r == 2'h1)
                ptr_r <= rx_byte;
              if (phase_r == 2'h2)
                ptr_r <= ptr_r + 8'h01;
              if (phase_r != 2'h2)
                phase_r <= phase_r + 2'h1;
            end
          end
        end
        EQC_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (read_r) begin
              // Read data starts straight after the address ack
              state_r      <= EQC_TX;
              shift_r      <= rd_data;
              sda_oe_n_out <= rd_data[7];
            end else begin
              state_r      <= EQC_RX;
              sda_oe_n_out <= 1'b1;
            end
          end
        end
        EQC_TX: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_r == eqc_pkg::BITS_PER_BYTE) begin
              state_r      <= EQC_RACK;
              sda_oe_n_out <= 1'b1;
              ptr_r        <= ptr_r + 8'h01;
            end else begin
              shift_r      <= {shift_r[6:0], 1'b0};
              sda_oe_n_out <= shift_r[6];
            end
          end
        end
        EQC_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= EQC_IDLE;
            end else begin
              state_r      <= EQC_TX;
              shift_r      <= rd_data;
              sda_oe_n_out <= rd_data[7];
            end
          end
        end
        default: begin
          sda_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // Pin value is always low; only the enable moves
  always_ff @(posedge sys_clk_in) begin
    sda_out <= 1'b0;
  end

  // ==========================================================
  // Writable registers
  logic [7:0] control_r;
  logic [7:0] threshold_r;
  logic [3:0] emphasis_r;
  logic [1:0] swing_r;
  logic [7:0] bandwidth_r;
  logic [7:0] absence_r;
  // Unmapped and read-only offsets drop the write
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      control_r   <= eqc_pkg::RST_CONTROL;
      threshold_r <= eqc_pkg::RST_THRESHOLD;
      emphasis_r  <= eqc_pkg::RST_EMPHASIS;
      swing_r     <= eqc_pkg::RST_SWING;
      bandwidth_r <= eqc_pkg::RST_BANDWIDTH;
      absence_r   <= eqc_pkg::RST_ABSENCE;
    end else if (wr_stb) begin
      case (ptr_r)
        eqc_pkg::OFS_CONTROL:   control_r   <= rx_byte;
        eqc_pkg::OFS_THRESHOLD: threshold_r <= rx_byte;
        eqc_pkg::OFS_EMPHASIS:  emphasis_r  <= rx_byte[3:0];
        eqc_pkg::OFS_SWING:     swing_r     <= rx_byte[1:0];
        eqc_pkg::OFS_BANDWIDTH: bandwidth_r <= rx_byte;
        eqc_pkg::OFS_ABSENCE:   absence_r   <= rx_byte;
        default:                ;
      endcase
    end
  end

  // ==========================================================
  // Settings in effect, one flop stage to the analog path
  logic serial_sel;
  assign serial_sel = control_r[eqc_pkg::BIT_SERIAL_SEL];
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      emphasis_code_out   <= eqc_pkg::RST_EMPHASIS;
      emphasis_step_out   <= 3'h0;
      swing_level_out     <= eqc_pkg::SWING_600;
      threshold_shift_out <= 8'sh00;
      bandwidth_code_out  <= BW_FIXED_CODE;
      absence_level_out   <= LVL_FIXED_CODE;
    end else begin
      // Register or pin source for the shared settings
      emphasis_code_out   <= serial_sel ? emphasis_r : pin_emph_s;
      emphasis_step_out   <= emph_step(serial_sel ? emphasis_r
                                                  : pin_emph_s);
      swing_level_out     <= swing_lvl(serial_sel ? swing_r
                                                  : pin_swing_s);
      threshold_shift_out <= thr_shift(serial_sel ? threshold_r
                                                  : pin_thr_s);
      // Bandwidth has no pin; the fixed code stands outside override
      if (serial_sel && bandwidth_r[eqc_pkg::BIT_OVR_ENABLE])
        bandwidth_code_out <= bandwidth_r[3:0];
      else
        bandwidth_code_out <= BW_FIXED_CODE;
      // Absence level: pin, register code or fixed level
      if (!serial_sel || control_r[eqc_pkg::BIT_PIN_OVERRIDE])
        absence_level_out <= pin_lvl_s;
      else if (absence_r[eqc_pkg::BIT_OVR_ENABLE])
        absence_level_out <= absence_r[6:0];
      else
        absence_level_out <= LVL_FIXED_CODE;
    end
  end

  // ==========================================================
  // Read mux; status reads the very flops that drive the analog path
  always_comb begin
    case (ptr_r)
      eqc_pkg::OFS_CONTROL:   rd_data = control_r;
      eqc_pkg::OFS_THRESHOLD: rd_data = threshold_r;
      eqc_pkg::OFS_EMPHASIS:  rd_data = {4'h0, emphasis_r};
      eqc_pkg::OFS_SWING:     rd_data = {6'h00, swing_r};
      eqc_pkg::OFS_BANDWIDTH: rd_data = bandwidth_r;
      eqc_pkg::OFS_ABSENCE:   rd_data = absence_r;
      eqc_pkg::OFS_EFF_BW:    rd_data = {4'h0, bandwidth_code_out};
      eqc_pkg::OFS_EFF_LVL:   rd_data = {1'b0, absence_level_out};
      default:                rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Assertions
  property p_emph_reg;
    @(posedge sys_clk_in) disable iff (reset_in)
    serial_sel |=> emphasis_code_out == $past(emphasis_r);
  endproperty
  a_emph_reg: assert property (p_emph_reg)
    else $error("emphasis not from register");
  property p_swing_rst;
    @(posedge sys_clk_in)
    reset_in ##1 !reset_in |-> swing_r == eqc_pkg::RST_SWING;
  endproperty
  a_swing_rst: assert property (p_swing_rst)
    else $error("swing reset value wrong");
  property p_bw_fixed;
    @(posedge sys_clk_in) disable iff (reset_in)
    !bandwidth_r[eqc_pkg::BIT_OVR_ENABLE] |=>
      bandwidth_code_out == BW_FIXED_CODE;
  endproperty
  a_bw_fixed: assert property (p_bw_fixed)
    else $error("fixed bandwidth not used");
  property p_bw_code;
    @(posedge sys_clk_in) disable iff (reset_in)
    serial_sel && bandwidth_r[eqc_pkg::BIT_OVR_ENABLE] |=>
      bandwidth_code_out == $past(bandwidth_r[3:0]);
  endproperty
  a_bw_code: assert property (p_bw_code)
    else $error("bandwidth code not applied");
  property p_lvl_fixed;
    @(posedge sys_clk_in) disable iff (reset_in)
    serial_sel && !control_r[eqc_pkg::BIT_PIN_OVERRIDE] &&
    !absence_r[eqc_pkg::BIT_OVR_ENABLE] |=>
      absence_level_out == LVL_FIXED_CODE;
  endproperty
  a_lvl_fixed: assert property (p_lvl_fixed)
    else $error("fixed absence level not used");
  property p_lvl_pin;
    @(posedge sys_clk_in) disable iff (reset_in)
    control_r[eqc_pkg::BIT_PIN_OVERRIDE] |=>
      absence_level_out == $past(pin_lvl_s);
  endproperty
  a_lvl_pin: assert property (p_lvl_pin)
    else $error("absence level pin override ignored");
  property p_pin_mode;
    @(posedge sys_clk_in) disable iff (reset_in)
    !serial_sel |=> emphasis_code_out == $past(pin_emph_s);
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("pin settings not active");
  property p_thr_mid;
    @(posedge sys_clk_in) disable iff (reset_in)
    serial_sel && threshold_r == eqc_pkg::THR_MID |=>
      threshold_shift_out == 8'sh00;
  endproperty
  a_thr_mid: assert property (p_thr_mid)
    else $error("mid threshold code not zero shift");
  property p_ro_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
    wr_stb && ptr_r == eqc_pkg::OFS_EFF_BW |=> $stable(bandwidth_r) ##1
      bandwidth_code_out == $past(bandwidth_code_out, 2);
  endproperty
  a_ro_hold: assert property (p_ro_hold)
    else $error("read-only write disturbed bandwidth");
  c_write: cover property (@(posedge sys_clk_in) wr_stb);
  c_read:  cover property (@(posedge sys_clk_in) state_r == EQC_TX);
  c_ovr:   cover property (@(posedge sys_clk_in)
                           control_r[eqc_pkg::BIT_PIN_OVERRIDE]);
endmodule

// >>> bench/eqc_host_model.sv
// Behavioural two-wire serial bus master standing in for the host
`timescale 1ns/1ps
module eqc_host_model (
  // Clock
  input  wire logic sys_clk_in,
  // Two-wire serial pins
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // ==========================================================
  // Idle bus: clock high and still, data released to the pull-up
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  // ==========================================================
  // Bit timing
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Data moves 4 clocks into the low phase so that the device's
  // synchronised clock has fallen first and sees no false START
  task automatic put_bit(input logic b, output logic got);
    tick(4);
    sda_oe_n_out <= b;
    tick(6);
    scl_out <= 1'b1;
    tick(10);
    got = sda_wire_in;
    scl_out <= 1'b0;
  endtask

  // Works from idle and as a repeated START after an acknowledge
  task automatic start();
    tick(4);
    sda_oe_n_out <= 1'b1;
    tick(6);
    scl_out <= 1'b1;
    tick(10);
    sda_oe_n_out <= 1'b0;
    tick(10);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    tick(4);
    sda_oe_n_out <= 1'b0;
    tick(6);
    scl_out <= 1'b1;
    tick(10);
    sda_oe_n_out <= 1'b1;
    tick(10);
  endtask

  // Eight bits MSB first, then the acknowledge bit; 1 releases
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(ack_in, ack);
  endtask

  // ==========================================================
  // Register transfers; nak is high if any byte went unanswered
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d[$], output logic nak);
    logic [7:0] rx;
    logic       ack;
    start();
    xfer({dev, 1'b0}, 1'b1, rx, ack);
    nak = ack;
    xfer(ptr, 1'b1, rx, ack);
    nak |= ack;
    foreach (d[i]) begin
      xfer(d[i], 1'b1, rx, ack);
      nak |= ack;
    end
    stop();
  endtask

  // Last byte is refused by the host so the device lets go of data
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr,
                           input int n, output logic [7:0] q[$],
                           output logic nak);
    logic [7:0] rx;
    logic       ack;
    q = {};
    start();
    xfer({dev, 1'b0}, 1'b1, rx, ack);
    nak = ack;
    xfer(ptr, 1'b1, rx, ack);
    nak |= ack;
    start();
    xfer({dev, 1'b1}, 1'b1, rx, ack);
    nak |= ack;
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, (i == n - 1), rx, ack);
      q.push_back(rx);
    end
    stop();
  endtask
endmodule

// >>> bench/test_eqc_config_regs.sv
// Self-checking testbench of the equalizer configuration register bank
`timescale 1ns/1ps
module test_eqc_config_regs;
  // ==========================================================
  // Parameters, tables and signals
  localparam logic [6:0] DEV     = 7'h2a; // Arbitrary neutral address
  localparam logic [3:0] BW_FIX  = 4'h3;  // Arbitrary fixed band code
  localparam logic [6:0] LVL_FIX = 7'h21; // Arbitrary fixed level code
  localparam logic [7:0] BW_BYTE = {4'h0, BW_FIX};
  localparam logic [3:0] EMC [8] = '{4'h0, 4'h1, 4'h3, 4'h4,
                                     4'h5, 4'h7, 4'hc, 4'hd};
  localparam logic [7:0] THI [8] = '{8'h00, 8'h80, 8'h01, 8'h7f,
                                     8'h81, 8'hff, 8'h40, 8'hc0};
  localparam logic [7:0] THE [8] = '{8'h00, 8'h00, 8'h7f, 8'h01,
                                     8'hff, 8'h81, 8'h40, 8'hc0};
  localparam logic [1:0] SWL [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
  logic              sys_clk = 1'b0; // 100 MHz clock
  logic              reset   = 1'b1; // Synchronous reset
  logic              scl;            // Host serial clock
  logic              host_oe_n;      // Host pulls data low when 0
  logic              dev_sda;        // Device data level
  logic              dev_oe_n;       // Device pulls data low when 0
  wire               sda_wire;       // Open-drain data line
  logic [3:0]        pin_em  = 4'h0; // Setting pins
  logic [1:0]        pin_sw  = 2'h0;
  logic [7:0]        pin_th  = 8'h00;
  logic [6:0]        pin_lv  = 7'h00;
  logic [3:0]        em_out;         // Settings in effect
  logic [2:0]        st_out;
  logic [1:0]        sw_out;
  logic signed [7:0] th_out;
  logic [3:0]        bw_out;
  logic [6:0]        lv_out;
  int                fails        = 0;
  int                total_checks = 0;
  logic [7:0]        q[$];           // Bytes read back
  logic              nak;            // Some byte went unanswered

  // Pull-up wins unless either party drives low
  assign sda_wire = host_oe_n & (dev_oe_n | dev_sda);
  always #5 sys_clk = ~sys_clk;

  eqc_config_regs #(
    .SLAVE_ADDR     (DEV),
    .BW_FIXED_CODE  (BW_FIX),
    .LVL_FIXED_CODE (LVL_FIX)
  ) i_dut (
    .sys_clk_in           (sys_clk),
    .reset_in             (reset),
    .scl_in               (scl),
    .sda_in               (sda_wire),
    .sda_out              (dev_sda),
    .sda_oe_n_out         (dev_oe_n),
    .pin_emphasis_in      (pin_em),
    .pin_swing_in         (pin_sw),
    .pin_threshold_in     (pin_th),
    .absence_level_pin_in (pin_lv),
    .emphasis_code_out    (em_out),
    .emphasis_step_out    (st_out),
    .swing_level_out      (sw_out),
    .threshold_shift_out  (th_out),
    .bandwidth_code_out   (bw_out),
    .absence_level_out    (lv_out)
  );

  eqc_host_model i_host (
    .sys_clk_in   (sys_clk),
    .sda_wire_in  (sda_wire),
    .scl_out      (scl),
    .sda_oe_n_out (host_oe_n)
  );

  // ==========================================================
  // Compare and access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // All six settings handed to the analog path
  task automatic chk_set(input logic [7:0] th, input logic [3:0] em,
                         input logic [2:0] st, input logic [1:0] sw,
                         input logic [3:0] bw, input logic [6:0] lv);
    check_byte(th_out, th);
    check_byte({4'h0, em_out}, {4'h0, em});
    check_byte({5'h0, st_out}, {5'h0, st});
    check_byte({6'h0, sw_out}, {6'h0, sw});
    check_byte({4'h0, bw_out}, {4'h0, bw});
    check_byte({1'b0, lv_out}, {1'b0, lv});
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    i_host.write_regs(DEV, ptr, d, nak);
    check_bit(nak, 1'b0);
  endtask

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e[$]);
    i_host.read_regs(DEV, ptr, e.size(), q, nak);
    check_bit(nak, 1'b0);
    foreach (e[i]) begin
      check_byte(q[i], e[i]);
    end
  endtask

  task automatic results();
    $display("Checks: %0d, mismatches: %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog: the tests need about 20400 cycles, so this leaves margin
  initial begin
    tick(40000);
    fails++;
    results();
  end

  // ==========================================================
  // Test sequence
  initial begin
    tick(8);
    reset <= 1'b0;
    tick(4);
    // Pin mode: every listed emphasis, swing and threshold code
    for (int i = 0; i < 8; i++) begin
      pin_em <= EMC[i];
      pin_sw <= 2'(i);
      pin_th <= THI[i];
      pin_lv <= 7'(i * 9 + 5);
      tick(5);
      chk_set(THE[i], EMC[i], 3'(i), SWL[i % 4], BW_FIX, 7'(i * 9 + 5));
    end
    pin_em <= 4'h2;
    tick(5);
    check_byte({5'h0, st_out}, 8'h00);
    pin_em <= 4'h4;
    pin_lv <= 7'h5a;
    tick(5);
    rd_chk(8'h00, {8'h00, 8'h00, 8'h00, 8'h01});
    rd_chk(8'h07, {8'h00});
    rd_chk(8'h0b, {8'h00, 8'h00, 8'h00, BW_BYTE, 8'h5a});
    $display("Test pin_mode finished");
    // Register mode with an auto-incremented burst
    wr(8'h00, {8'h01, 8'h81, 8'h0d, 8'h03});
    chk_set(8'hff, 4'hd, 3'h7, 2'h2, BW_FIX, LVL_FIX);
    rd_chk(8'h00, {8'h01, 8'h81, 8'h0d, 8'h03});
    wr(8'h01, {8'h01, 8'h00, 8'h00});
    chk_set(8'h7f, 4'h0, 3'h0, 2'h0, BW_FIX, LVL_FIX);
    // Second zero-shift code from the register side
    wr(8'h01, {8'h80});
    check_byte(th_out, 8'h00);
    $display("Test register_mode finished");
    // Bandwidth source and the read-only status copy
    wr(8'h07, {8'h0a});
    check_byte({4'h0, bw_out}, BW_BYTE);
    wr(8'h07, {8'h8f});
    check_byte({4'h0, bw_out}, 8'h0f);
    rd_chk(8'h0e, {8'h0f});
    wr(8'h07, {8'h80});
    wr(8'h0e, {8'hff});
    check_byte({4'h0, bw_out}, 8'h00);
    rd_chk(8'h0e, {8'h00});
    $display("Test bandwidth finished");
    // Absence level source, status copy and pin override
    wr(8'h0b, {8'h15});
    check_byte({1'b0, lv_out}, {1'b0, LVL_FIX});
    wr(8'h0b, {8'hff});
    check_byte({1'b0, lv_out}, 8'h7f);
    rd_chk(8'h0f, {8'h7f});
    wr(8'h0b, {8'h80});
    wr(8'h0f, {8'h55});
    check_byte({1'b0, lv_out}, 8'h00);
    rd_chk(8'h0e, {8'h00, 8'h00});
    wr(8'h00, {8'h81});
    check_byte({1'b0, lv_out}, 8'h5a);
    rd_chk(8'h0f, {8'h5a});
    $display("Test absence_level finished");
    // Wrong address is ignored; unmapped places hold nothing
    i_host.write_regs(DEV ^ 7'h01, 8'h02, {8'h05}, nak);
    check_bit(nak, 1'b1);
    check_byte({4'h0, em_out}, 8'h00);
    wr(8'h05, {8'haa});
    rd_chk(8'h03, {8'h00, 8'h00, 8'h00});
    wr(8'h00, {8'h00});
    chk_set(8'hc0, 4'h4, 3'h3, 2'h2, BW_FIX, 7'h5a);
    $display("Test refusals finished");
    results();
  end
endmodule
